// [spr_host.sv]
// APB host model that programs the register bank
`timescale 1ns/10ps
`default_nettype none
module spr_host
(
  // Clock
  input  wire logic        pclk,
  // APB master
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                      output logic [31:0] r, output logic e);
    logic [15:0] dw;
    dw = d;
    if (a == 12'h000)
      dw[15:14] = 2'h0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0, dw};
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines stop showing the old request
    paddr   <= ~a;
    pwdata  <= ~pwdata;
  endtask
endmodule
`default_nettype wire

// [spr_pkg.sv]
// Package for the synthesizer profile-one and control register bank
package spr_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [2:0] IDX_CTRL      = 3'h0;
  localparam logic [2:0] IDX_FRAC_HIGH = 3'h1;
  localparam logic [2:0] IDX_NUM_LOW   = 3'h2;
  localparam logic [2:0] IDX_DEN_LOW   = 3'h3;
  localparam logic [2:0] IDX_FEEDBACK  = 3'h4;
  localparam logic [2:0] IDX_REF_DIV   = 3'h5;
  localparam logic [2:0] IDX_LOOP_MULT = 3'h6;
  localparam logic [2:0] IDX_STATUS    = 3'h7;

  // Reset values
  localparam logic [15:0] RST_CTRL      = 16'h0003;
  localparam logic [15:0] RST_FRAC_HIGH = 16'h0000;
  localparam logic [15:0] RST_NUM_LOW   = 16'h0000;
  localparam logic [15:0] RST_DEN_LOW   = 16'h0000;
  localparam logic [15:0] RST_FEEDBACK  = 16'h0028;
  localparam logic [15:0] RST_REF_DIV   = 16'h0101;
  localparam logic [15:0] RST_LOOP_MULT = 16'h8584;

  // Control word bit positions
  localparam int CTRL_SOFT_RESET  = 13;
  localparam int CTRL_POWER_DOWN  = 12;
  localparam int CTRL_TXRX_SOURCE = 11;
  localparam int CTRL_CAL_ENABLE  = 0;
  localparam logic [15:0] CTRL_ZERO_MASK = 16'h3FFF;

  // Feedback register fields
  localparam int FB_PRESCALER = 15;
  localparam int FB_ORDER_LSB = 12;
  localparam int FB_INT_LSB   = 0;

  // Modulator modes
  typedef enum logic [4:0] {
    SPR_MOD_INTEGER = 5'h01,
    SPR_MOD_FIRST   = 5'h02,
    SPR_MOD_SECOND  = 5'h04,
    SPR_MOD_THIRD   = 5'h08,
    SPR_MOD_FOURTH  = 5'h10
  } spr_mod_e;

  // Decoded profile-one settings
  typedef struct packed {
    logic [2:0]  loop_resistor_code_p1;
    logic [2:0]  second_output_divider_p1;
    logic [1:0]  first_output_divider_p1;
    logic [2:0]  detector_delay_p1;
    logic [4:0]  reference_multiplier_p1;
    logic [7:0]  reference_divider_p1;
    logic [7:0]  reference_predivider_p1;
    logic [2:0]  feedback_prescaler_p1;
    spr_mod_e    modulator_order_p1;
    logic [11:0] feedback_integer_p1;
    logic [23:0] fraction_denominator_p1;
    logic [23:0] fraction_numerator_p1;
  } spr_profile_s;

  // Control outputs
  typedef struct packed {
    logic power_down;
    logic txrx_switch_source;
    logic calibration_start;
  } spr_ctrl_s;

endpackage

// [spr_regs.sv]
// APB register bank for synthesizer profile one and the control word
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Writing control bit 13 reloads control and profile registers to defaults (not status bit 0); bit self-clears.
// - Control bit 12 high powers the device down; low is normal operation.
// - Control bit 11 chooses register or pin control of TX/RX switching.
// - Control word resets to 0x3: bit 1 and calibration enable set.
// - Loop register holds resistor, two dividers, detector delay, multiplier fields.
// - Reference register holds divider high byte, pre-divider low byte, both 1.
// - Feedback register holds prescaler, modulator order, integer value 0x28.
// - 24-bit denominator joins offset 3 low word and offset 1 high byte.
// - 24-bit numerator joins offset 2 low word and offset 1 low byte.
// - Prescaler bit selects divide by 2 at 0, by 4 at 1.
// - Modulator order decodes 0 integer, 1-3 orders, 4-7 fourth order.
// - Control write with calibration enable and bit 13 clear starts calibration; otherwise none.
module spr_regs
(
  // Clock, reset, enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic                  pready,
  output var  logic [31:0]           prdata,
  output var  logic                  pslverr,
  // Transmit/receive control pin
  input  wire logic                  txrx_control_pin,
  // Synthesizer controls
  output var  spr_pkg::spr_profile_s profile,
  output var  spr_pkg::spr_ctrl_s    ctrl,
  output var  logic                  txrx_select
);

  //////////////////////////////////////////////////////////////////////////////

  logic [15:0] synth_control_word;
  logic [15:0] profile1_fraction_high;
  logic [15:0] profile1_numerator_low;
  logic [15:0] profile1_denominator_low;
  logic [15:0] profile1_feedback_config;
  logic [15:0] profile1_reference_dividers;
  logic [15:0] profile1_loop_multiplier;
  logic        pin_meta;
  logic        pin_sync;
  logic        txrx_reg_select;

  logic        access;
  logic        wr_hit;
  logic [2:0]  idx;
  logic        mapped;
  logic        soft_reset;
  logic [15:0] next_wdata;

  // Word index; only aligned words inside the map are accepted
  function automatic logic [2:0] word_index(input logic [11:0] a);
    word_index = a[4:2];
  endfunction

  // Merge written bytes into the low half-word of a register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic spr_pkg::spr_mod_e order_decode(input logic [2:0] o);
    unique case (o)
      3'h0:    order_decode = spr_pkg::SPR_MOD_INTEGER;
      3'h1:    order_decode = spr_pkg::SPR_MOD_FIRST;
      3'h2:    order_decode = spr_pkg::SPR_MOD_SECOND;
      3'h3:    order_decode = spr_pkg::SPR_MOD_THIRD;
      default: order_decode = spr_pkg::SPR_MOD_FOURTH;
    endcase
  endfunction

  assign access     = psel && penable && clk_en;
  assign idx        = word_index(paddr);
  assign mapped     = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign wr_hit     = access && pwrite && mapped;
  assign next_wdata = pwdata[15:0];

  // Soft reset request from a control word write
  assign soft_reset = wr_hit && (idx == spr_pkg::IDX_CTRL) && pstrb[1]
                      && next_wdata[spr_pkg::CTRL_SOFT_RESET];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_meta <= txrx_control_pin;
      pin_sync <= pin_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control word

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      synth_control_word <= spr_pkg::RST_CTRL;
    else if (soft_reset)
      // Reset bit never stored, so it reads back cleared
      synth_control_word <= spr_pkg::RST_CTRL;
    else if (wr_hit && idx == spr_pkg::IDX_CTRL)
      // Hold until rewritten; reset bit kept clear
      synth_control_word <= merge(synth_control_word, pwdata, pstrb)
                            & ~(16'h0001 << spr_pkg::CTRL_SOFT_RESET);
  end

  // Profile registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      profile1_fraction_high      <= spr_pkg::RST_FRAC_HIGH;
      profile1_numerator_low      <= spr_pkg::RST_NUM_LOW;
      profile1_denominator_low    <= spr_pkg::RST_DEN_LOW;
      profile1_feedback_config    <= spr_pkg::RST_FEEDBACK;
      profile1_reference_dividers <= spr_pkg::RST_REF_DIV;
      profile1_loop_multiplier    <= spr_pkg::RST_LOOP_MULT;
    end
    else if (soft_reset)
    begin
      profile1_fraction_high      <= spr_pkg::RST_FRAC_HIGH;
      profile1_numerator_low      <= spr_pkg::RST_NUM_LOW;
      profile1_denominator_low    <= spr_pkg::RST_DEN_LOW;
      profile1_feedback_config    <= spr_pkg::RST_FEEDBACK;
      profile1_reference_dividers <= spr_pkg::RST_REF_DIV;
      profile1_loop_multiplier    <= spr_pkg::RST_LOOP_MULT;
    end
    else if (wr_hit)
    begin
      // Written fields hold until the next write
      unique case (idx)
        spr_pkg::IDX_FRAC_HIGH:
          profile1_fraction_high <= merge(profile1_fraction_high, pwdata, pstrb);
        spr_pkg::IDX_NUM_LOW:
          profile1_numerator_low <= merge(profile1_numerator_low, pwdata, pstrb);
        spr_pkg::IDX_DEN_LOW:
          profile1_denominator_low <= merge(profile1_denominator_low, pwdata, pstrb);
        spr_pkg::IDX_FEEDBACK:
          profile1_feedback_config <= merge(profile1_feedback_config, pwdata, pstrb);
        spr_pkg::IDX_REF_DIV:
          profile1_reference_dividers <= merge(profile1_reference_dividers, pwdata, pstrb);
        spr_pkg::IDX_LOOP_MULT:
          profile1_loop_multiplier <= merge(profile1_loop_multiplier, pwdata, pstrb);
        default:
          ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs to the synthesizer core

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      profile <= '0;
      ctrl    <= '0;
    end
    else if (clk_en)
    begin
      profile.loop_resistor_code_p1    <= profile1_loop_multiplier[15:13];
      profile.second_output_divider_p1 <= profile1_loop_multiplier[12:10];
      profile.first_output_divider_p1  <= profile1_loop_multiplier[9:8];
      profile.detector_delay_p1        <= profile1_loop_multiplier[7:5];
      profile.reference_multiplier_p1  <= profile1_loop_multiplier[4:0];
      profile.reference_divider_p1    <= profile1_reference_dividers[15:8];
      profile.reference_predivider_p1 <= profile1_reference_dividers[7:0];
      profile.feedback_prescaler_p1 <= profile1_feedback_config[spr_pkg::FB_PRESCALER]
                                       ? 3'h4 : 3'h2;
      profile.modulator_order_p1  <= order_decode(
                                       profile1_feedback_config[spr_pkg::FB_ORDER_LSB +: 3]);
      profile.feedback_integer_p1 <= profile1_feedback_config[spr_pkg::FB_INT_LSB +: 12];
      profile.fraction_denominator_p1 <= {profile1_fraction_high[15:8],
                                          profile1_denominator_low};
      profile.fraction_numerator_p1 <= {profile1_fraction_high[7:0], profile1_numerator_low};
      ctrl.power_down <= synth_control_word[spr_pkg::CTRL_POWER_DOWN];
      ctrl.txrx_switch_source <= synth_control_word[spr_pkg::CTRL_TXRX_SOURCE];
      // One-cycle calibration start on an enabled control write
      ctrl.calibration_start <= wr_hit && idx == spr_pkg::IDX_CTRL && !soft_reset
                                && pstrb[0] && next_wdata[spr_pkg::CTRL_CAL_ENABLE];
    end
  end

  // Register-chosen TX/RX path, bit 0 of the status word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txrx_reg_select <= 1'b0;
    else if (wr_hit && idx == spr_pkg::IDX_STATUS && pstrb[0])
      txrx_reg_select <= pwdata[0];
  end

  // Switch source picks register or pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txrx_select <= 1'b0;
    else if (clk_en)
      txrx_select <= synth_control_word[spr_pkg::CTRL_TXRX_SOURCE]
                     ? pin_sync : txrx_reg_select;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer: zero wait states, error on unmapped address

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      // Ready rises at the end of the setup cycle so the access phase lasts one cycle
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite && mapped)
      begin
        unique case (idx)
          spr_pkg::IDX_CTRL:      prdata <= {16'h0000, synth_control_word};
          spr_pkg::IDX_FRAC_HIGH: prdata <= {16'h0000, profile1_fraction_high};
          spr_pkg::IDX_NUM_LOW:   prdata <= {16'h0000, profile1_numerator_low};
          spr_pkg::IDX_DEN_LOW:   prdata <= {16'h0000, profile1_denominator_low};
          spr_pkg::IDX_FEEDBACK:  prdata <= {16'h0000, profile1_feedback_config};
          spr_pkg::IDX_REF_DIV:   prdata <= {16'h0000, profile1_reference_dividers};
          spr_pkg::IDX_LOOP_MULT: prdata <= {16'h0000, profile1_loop_multiplier};
          spr_pkg::IDX_STATUS:    prdata <= {29'h0000_0000, pin_sync, txrx_select,
                                             txrx_reg_select};
        endcase
      end
      else
        prdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [spr_regs_chk.sv]
// Port assertions for the synthesizer register bank
`timescale 1ns/10ps
`default_nettype none
module spr_regs_chk
(
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  clk_en,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // Synthesizer side
  input wire spr_pkg::spr_profile_s profile,
  input wire spr_pkg::spr_ctrl_s    ctrl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctl_wr;
  logic fb_wr;
  // Only full-strobe writes, so every field of the word really lands
  assign ctl_wr = psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[1:0] == 2'h3;
  assign fb_wr  = psel && penable && pready && pwrite && paddr == 12'h010 && pstrb[1:0] == 2'h3;
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_zero_wait: assert property (psel && !penable && clk_en |=> pready)
    else $error("pready missing in access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_rdata_clean: assert property (prdata[31:16] == 16'h0 && (pready || prdata == 32'h0))
    else $error("prdata not clean");
  a_err_unmapped: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_soft_defaults: assert property (ctl_wr && pwdata[13] |-> ##2
    profile.feedback_integer_p1 == 12'h028 && profile.reference_divider_p1 == 8'h01
    && !ctrl.power_down) else $error("soft reset did not restore defaults");
  a_pd_follow: assert property (ctl_wr && !pwdata[13] |-> ##2
    ctrl.power_down == $past(pwdata[12], 2)) else $error("power down wrong");
  a_src_follow: assert property (ctl_wr && !pwdata[13] |-> ##2
    ctrl.txrx_switch_source == $past(pwdata[11], 2)) else $error("switch source wrong");
  a_cal_start: assert property (ctl_wr && pwdata[0] && !pwdata[13] |-> ##[1:2]
    ctrl.calibration_start) else $error("calibration not started");
  a_cal_pulse: assert property (ctrl.calibration_start |=> !ctrl.calibration_start)
    else $error("calibration start not a pulse");
  a_fb_integer: assert property (fb_wr |-> ##2
    profile.feedback_integer_p1 == $past(pwdata[11:0], 2)) else $error("integer wrong");
  a_prescaler: assert property (fb_wr |-> ##2
    profile.feedback_prescaler_p1 == ($past(pwdata[15], 2) ? 3'h4 : 3'h2))
    else $error("prescaler wrong");
endmodule
`default_nettype wire

// [test_spr_regs.sv]
// Self-checking bench for the synthesizer register bank
`timescale 1ns/10ps
`default_nettype none
module test_spr_regs;
  logic pclk, presetn, clk_en, txrx_control_pin, psel, penable, pwrite, pready, pslverr;
  logic txrx_select, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  spr_pkg::spr_profile_s profile;
  spr_pkg::spr_ctrl_s    ctrl;
  int errors, n_checks, cycles, cal_seen;
  localparam logic [15:0] DEF [7] = '{16'h0003, 16'h0000, 16'h0000, 16'h0000,
                                      16'h0028, 16'h0101, 16'h8584};
  spr_regs uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .txrx_control_pin(txrx_control_pin),
    .profile(profile), .ctrl(ctrl), .txrx_select(txrx_select));
  spr_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (ctrl.calibration_start === 1'b1)
      cal_seen <= cal_seen + 1;
    if (cycles == 30000)
    begin
      errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, rv, ev);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0, rv, ev);
    chk("read data", {16'h0, e}, rv);
  endtask
  task automatic t_defaults;
    for (int i = 0; i < 7; i++)
      rd(12'(4 * i), DEF[i]);
    chk("integer", 32'(profile.feedback_integer_p1), 32'h28);
    chk("power down", 32'(ctrl.power_down), 32'h0);
  endtask
  task automatic t_fields;
    wr(12'h004, 16'hA55A);
    wr(12'h008, 16'h1234);
    wr(12'h00C, 16'hBEEF);
    wr(12'h014, 16'h7F3C);
    wr(12'h018, 16'hE7F5);
    rd(12'h004, 16'hA55A);
    rd(12'h018, 16'hE7F5);
    repeat (2) @(posedge pclk);
    chk("numerator", 32'(profile.fraction_numerator_p1), 32'h5A1234);
    chk("denominator", 32'(profile.fraction_denominator_p1), 32'hA5BEEF);
    chk("ref divider", 32'(profile.reference_divider_p1), 32'h7F);
    chk("predivider", 32'(profile.reference_predivider_p1), 32'h3C);
    chk("multiplier", 32'(profile.reference_multiplier_p1), 32'h15);
    chk("loop code", 32'(profile.loop_resistor_code_p1), 32'h7);
    chk("divider two", 32'(profile.second_output_divider_p1), 32'h1);
    chk("divider one", 32'(profile.first_output_divider_p1), 32'h3);
    chk("detector delay", 32'(profile.detector_delay_p1), 32'h7);
  endtask
  task automatic t_decode;
    logic [4:0] m;
    for (int o = 0; o < 8; o++)
    begin
      m = (o > 3) ? 5'h10 : 5'(5'h01 << o);
      wr(12'h010, {o[0], 3'(o), 12'h3FF});
      repeat (2) @(posedge pclk);
      chk("order", 32'(profile.modulator_order_p1), 32'(m));
      chk("prescaler", 32'(profile.feedback_prescaler_p1), o[0] ? 32'h4 : 32'h2);
    end
  endtask
  task automatic t_ctrl;
    int c0;
    c0 = cal_seen;
    wr(12'h000, 16'h1000);
    repeat (2) @(posedge pclk);
    chk("power down", 32'(ctrl.power_down), 32'h1);
    wr(12'h000, 16'h0002);
    repeat (2) @(posedge pclk);
    chk("power down", 32'(ctrl.power_down), 32'h0);
    repeat (20000) @(posedge pclk);
    wr(12'h000, 16'hC003);
    repeat (3) @(posedge pclk);
    chk("cal pulses", 32'(cal_seen - c0), 32'h1);
    rd(12'h000, 16'h0003);
  endtask
  task automatic t_txrx;
    wr(12'h01C, 16'h0001);
    wr(12'h000, 16'h0002);
    repeat (5) @(posedge pclk);
    chk("select reg", 32'(txrx_select), 32'h1);
    wr(12'h000, 16'h0802);
    repeat (5) @(posedge pclk);
    chk("select pin", 32'(txrx_select), 32'h0);
    txrx_control_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("select pin", 32'(txrx_select), 32'h1);
    // Status word: register choice, selected path and synchronised pin all high
    rd(12'h01C, 16'h0007);
    // Clock enable low must freeze the pin path
    clk_en <= 1'b0;
    txrx_control_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("frozen select", 32'(txrx_select), 32'h1);
    clk_en <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("select pin", 32'(txrx_select), 32'h0);
  endtask
  task automatic t_soft_refused;
    wr(12'h000, 16'h2000);
    t_defaults();
    host.xfer(1'b1, 12'h012, 16'hFFFF, rv, ev);
    chk("slverr", 32'(ev), 32'h1);
    rd(12'h010, 16'h0028);
    chk("slverr", 32'(ev), 32'h0);
    host.xfer(1'b0, 12'h020, 16'h0, rv, ev);
    chk("slverr", 32'(ev), 32'h1);
  endtask
  task automatic final_report;
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    txrx_control_pin = 1'b0;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    cal_seen = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_fields();
    t_decode();
    t_ctrl();
    t_txrx();
    t_soft_refused();
    final_report();
  end
endmodule
bind spr_regs spr_regs_chk chk_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .profile(profile), .ctrl(ctrl));
`default_nettype wire
